// ===== core/sie_defines.vh
// Purpose: constants for the safety input evaluator
// Assumes: 10 MHz clock, plain register port, 4-bit byte address
// Notes: times in ms except SIE_TP_CYC, which is in clock cycles; ms converted to cycles in the module
`ifndef SIE_DEFINES_VH
`define SIE_DEFINES_VH
`define SIE_CLK_KHZ 16'h2710
`define SIE_TICK_MS 16'h0001
`define SIE_FILT_MIN 8'h03
`define SIE_FILT_MAX 8'hfa
`define SIE_FILT_RST 8'h03
`define SIE_SIM_RST 8'h32
`define SIE_TP_PER_MS 8'h0a
`define SIE_TP_CYC 4'h5
`define SIE_A_CFG 4'h0
`define SIE_A_FILT 4'h4
`define SIE_A_SIM 4'h8
`define SIE_A_STAT 4'hc
`define SIE_CFG_RST 12'h000
`define SIE_B_MAT_RST 0
`define SIE_B_MAT_MON 1
`define SIE_B_MAT_SUT 2
`define SIE_B_MAT_TP 3
`define SIE_B_SW_RST 4
`define SIE_B_SW_MON 5
`define SIE_B_SW_SUT 6
`define SIE_B_SW_TP 7
`define SIE_B_GRIP3 8
`define SIE_B_GRIP_SUT 9
`define SIE_B_GRIP_TP 10
`define SIE_B_ERR_EN 11
`define SIE_NCH 8
`define SIE_NTP 6
`define SIE_LAST_TP 3'h5
`endif

// ===== core/sie_top.v
// Purpose: mat, switch and enabling grip evaluator
// Assumes: contact inputs synchronous to clk_i
// Notes: channels 0..5 carry test pulses, 6..7 are reset inputs
`timescale 1ns/1ns
`include "sie_defines.vh"
module sie_top #(
	parameter [15:0] MS_CYC = `SIE_CLK_KHZ * `SIE_TICK_MS,
	parameter [7:0]  TP_PER = `SIE_TP_PER_MS,
	parameter [3:0]  TP_CYC = `SIE_TP_CYC
) (
	// Clock and reset
	input  wire        clk_i,
	input  wire        resetn_i,
	input  wire        ce_i,
	// Register port
	input  wire [3:0]  addr_i,
	input  wire [31:0] wdata_i,
	input  wire        we_i,
	input  wire        re_i,
	output wire [31:0] rdata_o,
	// Mat contacts and reset
	input  wire        mat_a_i,
	input  wire        mat_b_i,
	input  wire        mat_rst_i,
	// Switch contact and reset
	input  wire        sw_i,
	input  wire        sw_rst_i,
	// Grip contacts
	input  wire        contact_input_first_i,
	input  wire        contact_input_second_i,
	input  wire        contact_input_third_i,
	// Test pulse outputs, one per contact channel
	output wire [5:0]  tst_o,
	// Function outputs
	output wire        mat_out_o,
	output wire        sw_out_o,
	output wire        grip_out_o,
	output wire        mat_err_o,
	output wire        sw_err_o,
	output wire        grip_err_o
);

	localparam [1:0] S_IDLE = 2'h0;
	localparam [1:0] S_RISE = 2'h1;
	localparam [1:0] S_FALL = 2'h2;
	localparam [1:0] S_ON   = 2'h3;

	reg  [11:0] cfg_r;
	reg  [7:0]  filt_r;
	reg  [7:0]  sim_r;
	reg  [31:0] rdata_r;
	reg  [15:0] ms_cnt_r;
	reg         tick_r;
	reg  [7:0]  tp_ms_r;
	reg  [2:0]  tp_ch_r;
	reg  [3:0]  tp_cnt_r;
	reg         tp_act_r;
	reg  [7:0]  sim_cnt_r;
	reg         sim_f_r;
	reg  [7:0]  fe;
	wire [7:0]  raw;
	wire [7:0]  flt;
	wire [5:0]  tf;
	wire [5:0]  tp_en;
	wire [2:0]  cond;
	wire [2:0]  sut_c;
	wire [2:0]  rst_f;
	wire [2:0]  rst_en;
	wire [2:0]  rst_mon;
	wire [2:0]  sut_en;
	wire [2:0]  fault;
	wire [2:0]  out_w;
	wire [2:0]  err_w;
	wire        g3;
	wire        g_mid;
	wire        g_rel;
	wire        g_valid;
	wire        tp_last;

	assign raw = {sw_rst_i, mat_rst_i, contact_input_third_i,
		contact_input_second_i, contact_input_first_i, sw_i, mat_b_i, mat_a_i};

	// Register port
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			cfg_r   <= `SIE_CFG_RST;
			filt_r  <= `SIE_FILT_RST;
			sim_r   <= `SIE_SIM_RST;
			rdata_r <= 32'h0;
		end else if (ce_i) begin
			if (we_i) begin
				case (addr_i)
				`SIE_A_CFG:  cfg_r  <= wdata_i[11:0];
				`SIE_A_FILT: filt_r <= wdata_i[7:0];
				`SIE_A_SIM:  sim_r  <= wdata_i[7:0];
				default: ;
				endcase
			end
			rdata_r <= 32'h0;
			if (re_i) begin
				case (addr_i)
				`SIE_A_CFG:  rdata_r <= {20'h0, cfg_r};
				`SIE_A_FILT: rdata_r <= {24'h0, filt_r};
				`SIE_A_SIM:  rdata_r <= {24'h0, sim_r};
				`SIE_A_STAT: rdata_r <= {19'h0, tf, sim_f_r, fault, out_w};
				default:     rdata_r <= 32'h0;
				endcase
			end
		end
	end
	assign rdata_o = rdata_r;

	// Out-of-range filter settings are clamped rather than rejected
	always @* begin
		fe = filt_r;
		if (filt_r < `SIE_FILT_MIN)
			fe = `SIE_FILT_MIN;
		else if (filt_r > `SIE_FILT_MAX)
			fe = `SIE_FILT_MAX;
	end

	// Millisecond tick
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			ms_cnt_r <= 16'h0;
			tick_r   <= 1'b0;
		end else if (ce_i) begin
			tick_r <= (ms_cnt_r == MS_CYC - 16'h1);
			if (ms_cnt_r == MS_CYC - 16'h1)
				ms_cnt_r <= 16'h0;
			else
				ms_cnt_r <= ms_cnt_r + 16'h1;
		end
	end

	// Test pulse scheduler, one channel at a time so a short shows up
	assign tp_last = tp_act_r && (tp_cnt_r == TP_CYC - 4'h1);
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			tp_ms_r  <= 8'h0;
			tp_ch_r  <= 3'h0;
			tp_cnt_r <= 4'h0;
			tp_act_r <= 1'b0;
		end else if (ce_i) begin
			if (tick_r && !tp_act_r) begin
				if (tp_ms_r == TP_PER - 8'h1) begin
					tp_ms_r  <= 8'h0;
					tp_act_r <= 1'b1;
					tp_cnt_r <= 4'h0;
				end else
					tp_ms_r <= tp_ms_r + 8'h1;
			end
			if (tp_act_r)
				tp_cnt_r <= tp_cnt_r + 4'h1;
			if (tp_last) begin
				tp_act_r <= 1'b0;
				tp_ch_r  <= (tp_ch_r == `SIE_LAST_TP) ? 3'h0 : tp_ch_r + 3'h1;
			end
		end
	end

	assign tp_en = {{3{cfg_r[`SIE_B_GRIP_TP]}}, cfg_r[`SIE_B_SW_TP],
		{2{cfg_r[`SIE_B_MAT_TP]}}};

	genvar k;
	generate
		for (k = 0; k < `SIE_NCH; k = k + 1) begin : g_ch
			reg       flt_r;
			reg [7:0] db_r;
			wire      hold;
			wire      frz;
			if (k < `SIE_NTP) begin : g_tp
				localparam [2:0] CH = k;
				reg tf_r;
				reg tst_r;
				assign hold = tp_act_r && (tp_ch_r == CH) && tp_en[k];
				// The line stays low one cycle past hold, as tst_r is registered
				assign frz  = hold || !tst_r;
				// Each test line feeds exactly one contact channel
				always @(posedge clk_i or negedge resetn_i) begin
					if (!resetn_i) begin
						tst_r <= 1'b1;
						tf_r  <= 1'b0;
					end else if (ce_i) begin
						tst_r <= !hold;
						if (tp_last && (tp_ch_r == CH) && tp_en[k])
							tf_r <= raw[k];
						else if (!tp_en[k])
							tf_r <= 1'b0;
					end
				end
				assign tf[k]    = tf_r;
				assign tst_o[k] = tst_r;
			end else begin : g_nt
				assign hold = 1'b0;
				assign frz  = 1'b0;
			end
			// Samples taken while the line is pulsed are ignored
			always @(posedge clk_i or negedge resetn_i) begin
				if (!resetn_i) begin
					flt_r <= 1'b0;
					db_r  <= 8'h0;
				end else if (ce_i && !frz) begin
					if (raw[k] == flt_r)
						db_r <= 8'h0;
					else if (tick_r) begin
						if (db_r >= fe - 8'h1) begin
							flt_r <= raw[k];
							db_r  <= 8'h0;
						end else
							db_r <= db_r + 8'h1;
					end
				end
			end
			assign flt[k] = flt_r;
		end
	endgenerate

	// Grip decoding; with two contacts the third is ignored
	assign g3      = cfg_r[`SIE_B_GRIP3];
	assign g_mid   = flt[3] && flt[4] && (flt[5] || !g3);
	assign g_rel   = !flt[3] && !flt[4] && (flt[5] || !g3);
	assign g_valid = (flt[3] == flt[4]) && (!g3 || flt[5] || !flt[3]);

	// Simultaneity window on the grip, always active
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sim_cnt_r <= 8'h0;
			sim_f_r   <= 1'b0;
		end else if (ce_i) begin
			if (g_valid) begin
				sim_cnt_r <= 8'h0;
				sim_f_r   <= 1'b0;
			end else if (tick_r) begin
				if (sim_cnt_r >= sim_r)
					sim_f_r <= 1'b1;
				else
					sim_cnt_r <= sim_cnt_r + 8'h1;
			end
		end
	end

	assign cond    = {g_mid, flt[2], flt[0] && flt[1]};
	assign sut_c   = {g_rel, flt[2], flt[0] && flt[1]};
	assign rst_f   = {1'b0, flt[7], flt[6]};
	assign rst_en  = {1'b0, cfg_r[`SIE_B_SW_RST], cfg_r[`SIE_B_MAT_RST]};
	assign rst_mon = {1'b0, cfg_r[`SIE_B_SW_MON], cfg_r[`SIE_B_MAT_MON]};
	assign sut_en  = {cfg_r[`SIE_B_GRIP_SUT], cfg_r[`SIE_B_SW_SUT],
		cfg_r[`SIE_B_MAT_SUT]};
	assign fault   = {(|tf[5:3]) || sim_f_r, tf[2], tf[0] || tf[1]};

	generate
		for (k = 0; k < 3; k = k + 1) begin : g_blk
			reg  [1:0] st_r;
			reg  [1:0] st_next;
			reg        rp_r;
			reg        arm_r;
			reg        seen_r;
			reg        done_r;
			reg        out_r;
			reg        err_r;
			wire       ok;
			wire       rise;
			wire       fall;
			assign ok   = cond[k] && !fault[k];
			assign rise = rst_f[k] && !rp_r;
			assign fall = !rst_f[k] && rp_r;
			always @* begin
				st_next = st_r;
				if (!ok)
					st_next = S_IDLE;
				else begin
					case (st_r)
					S_IDLE: st_next = rst_en[k] ? S_RISE : S_ON;
					S_RISE: if (rise)
						st_next = rst_mon[k] ? S_FALL : S_ON;
					S_FALL: if (fall)
						st_next = S_ON;
					S_ON:   st_next = S_ON;
					default: st_next = S_IDLE;
					endcase
				end
			end
			// Start-up test latches only once per power-on
			always @(posedge clk_i or negedge resetn_i) begin
				if (!resetn_i) begin
					st_r   <= S_IDLE;
					rp_r   <= 1'b0;
					arm_r  <= 1'b0;
					seen_r <= 1'b0;
					done_r <= 1'b0;
					out_r  <= 1'b0;
					err_r  <= 1'b0;
				end else if (ce_i) begin
					st_r <= st_next;
					rp_r <= rst_f[k];
					// Filters wake at 0, which mimics an activation; only a change after an idle state counts
					if (sut_c[k])
						arm_r <= 1'b1;
					if (arm_r && !sut_c[k])
						seen_r <= 1'b1;
					if (seen_r && sut_c[k])
						done_r <= 1'b1;
					out_r <= ok && (done_r || !sut_en[k]) && (st_next == S_ON);
					err_r <= cfg_r[`SIE_B_ERR_EN] && fault[k];
				end
			end
			assign out_w[k] = out_r;
			assign err_w[k] = err_r;
		end
	endgenerate

	assign mat_out_o  = out_w[0];
	assign sw_out_o   = out_w[1];
	assign grip_out_o = out_w[2];
	assign mat_err_o  = err_w[0];
	assign sw_err_o   = err_w[1];
	assign grip_err_o = err_w[2];

endmodule // sie_top

// ===== dv/sie_top_props.sv
// Purpose: port checks for sie_top
// Assumes: default pulse length, ce_i low only while test pulses are off
// Notes: filter counts skip test pulses
`timescale 1ns/1ns
module sie_top_props #(parameter [15:0] MS_CYC = 16'h000a) (
	input wire        clk_i, resetn_i, ce_i, re_i,
	input wire        mat_a_i, mat_b_i, contact_input_first_i, contact_input_second_i,
	input wire [31:0] rdata_o,
	input wire [5:0]  tst_o,
	input wire        mat_out_o, sw_out_o, grip_out_o, mat_err_o, sw_err_o, grip_err_o
);
	reg [15:0] mat_cnt;
	reg [15:0] grip_cnt;
	// A pulse drags the line low on purpose, so it must not restart a count
	always @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			mat_cnt <= 16'h0000;
			grip_cnt <= 16'h0000;
		end else begin
			if (!(mat_a_i && mat_b_i) && tst_o[0] && tst_o[1])
				mat_cnt <= 16'h0000;
			else if (mat_cnt != 16'hffff)
				mat_cnt <= mat_cnt + 16'h0001;
			if (!(contact_input_first_i && contact_input_second_i) && tst_o[3] && tst_o[4])
				grip_cnt <= 16'h0000;
			else if (grip_cnt != 16'hffff)
				grip_cnt <= grip_cnt + 16'h0001;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	mat_fault_low_a: assert property (mat_err_o && $past(mat_err_o) |-> !mat_out_o)
		else $error("mat output high in fault");
	sw_fault_low_a: assert property (sw_err_o && $past(sw_err_o) |-> !sw_out_o)
		else $error("switch output high in fault");
	grip_fault_low_a: assert property (grip_err_o && $past(grip_err_o) |-> !grip_out_o)
		else $error("grip output high in fault");
	rdata_idle_a: assert property ($past(ce_i) && !$past(re_i) |-> rdata_o == 32'h0)
		else $error("read data without read");
	pulse_len_a: assert property ($fell(tst_o[0]) |-> (!tst_o[0]) [*5] ##1 tst_o[0])
		else $error("test pulse length wrong");
	one_pulse_a: assert property ($countones(~tst_o) <= 1)
		else $error("two test pulses at once");
	mat_filter_a: assert property ($rose(mat_out_o) |-> mat_cnt >= 2 * MS_CYC)
		else $error("mat output rose unfiltered");
	grip_filter_a: assert property ($rose(grip_out_o) |-> grip_cnt >= 2 * MS_CYC)
		else $error("grip output rose unfiltered");
endmodule // sie_top_props
bind sie_top sie_top_props #(.MS_CYC(MS_CYC)) u_props (.clk_i, .resetn_i, .ce_i, .re_i,
	.mat_a_i, .mat_b_i, .contact_input_first_i, .contact_input_second_i, .rdata_o, .tst_o,
	.mat_out_o, .sw_out_o, .grip_out_o, .mat_err_o, .sw_err_o, .grip_err_o);

// ===== dv/sie_contacts.sv
// Purpose: field contacts behind the test outputs
// Assumes: plain dry contacts
// Notes: a short ties its channel high
`timescale 1ns/1ns
module sie_contacts (
	input  wire [5:0] tst_i,
	input  wire [5:0] closed_i,
	input  wire [5:0] short_i,
	output wire [5:0] line_o
);
	// Bare contacts, no termination resistance
	assign line_o = short_i | (closed_i & tst_i);
endmodule // sie_contacts

// ===== dv/safety_input_evaluator_tb_top.sv
// Purpose: bench for sie_top
// Assumes: 1 ms shortened to 10 cycles
// Notes: lines driven through sie_contacts
`timescale 1ns/1ns
module safety_input_evaluator_tb_top;
	localparam [15:0] MSC = 16'h000a;
	localparam [17:0] GP = {6'h00, 6'h38, 6'h20};
	reg        clk = 0, rstn = 0, we = 0, re = 0, mrst = 0, ce = 1;
	reg [3:0]  addr = 4'h0;
	reg [31:0] wdata = 32'h0;
	reg [5:0]  cl = 6'h00;
	reg [5:0]  short = 6'h00;
	wire [5:0] tst, ln;
	wire [31:0] rdata;
	wire       mo, so, go, me, se, ge;
	int        error_cnt = 0, n_tests = 0, cyc = 0;
	always #50 clk = ~clk;
	sie_contacts u_dev (.tst_i(tst), .closed_i(cl), .short_i(short), .line_o(ln));
	sie_top #(.MS_CYC(MSC)) uut (.clk_i(clk), .resetn_i(rstn), .ce_i(ce), .addr_i(addr), .wdata_i(wdata),
		.we_i(we), .re_i(re), .rdata_o(rdata), .mat_a_i(ln[0]), .mat_b_i(ln[1]), .mat_rst_i(mrst),
		.sw_i(ln[2]), .sw_rst_i(mrst), .contact_input_first_i(ln[3]), .contact_input_second_i(ln[4]),
		.contact_input_third_i(ln[5]), .tst_o(tst), .mat_out_o(mo), .sw_out_o(so), .grip_out_o(go),
		.mat_err_o(me), .sw_err_o(se), .grip_err_o(ge));
	task summarize;
		if (error_cnt == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input string nm, input [31:0] e, input [31:0] g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("FAIL %s exp %h got %h", nm, e, g);
		end
	endtask
	task wr(input [3:0] a, input [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		we <= 1'b1;
		@(posedge clk);
		we <= 1'b0;
	endtask
	task rd(input [3:0] a, input [31:0] e);
		@(posedge clk);
		addr <= a;
		re <= 1'b1;
		@(posedge clk);
		re <= 1'b0;
		#1 chk("rdata", e, rdata);
	endtask
	task ms(input int n);
		repeat (n * MSC) @(posedge clk);
		#1;
	endtask
	task set(input [5:0] c, input int n);
		@(posedge clk);
		cl <= c;
		ms(n);
	endtask
	task rpin(input b);
		@(posedge clk);
		mrst <= b;
		ms(6);
	endtask
	// Cut a hang short well past the expected run of about 3000 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 10000) begin
			error_cnt++;
			summarize;
		end
	end
	initial begin
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		rd(4'h0, 32'h0);
		rd(4'h4, 32'h3);
		rd(4'h8, 32'h32);
		rd(4'h2, 32'h0);
		wr(4'hc, 32'hfff);
		rd(4'hc, 32'h0);
		wr(4'h4, 32'hfa);
		rd(4'h4, 32'hfa);
		wr(4'h4, 32'h3);
		set(6'h03, 6);
		chk("mat_out", 1, mo);
		set(6'h00, 6);
		chk("mat_out", 0, mo);
		set(6'h04, 6);
		chk("sw_out", 1, so);
		set(6'h18, 6);
		chk("sw_out", 0, so);
		chk("grip_out", 1, go);
		wr(4'h0, 32'h100);
		for (int i = 0; i < 3; i++) begin
			set(GP[i*6 +: 6], 6);
			chk("grip_out", i == 1, go);
		end
		wr(4'h0, 32'h1);
		set(6'h03, 6);
		chk("mat_out", 0, mo);
		rpin(1'b1);
		chk("mat_out", 1, mo);
		rpin(1'b0);
		set(6'h00, 6);
		set(6'h03, 6);
		chk("mat_out", 0, mo);
		wr(4'h0, 32'h3);
		rpin(1'b1);
		chk("mat_out", 0, mo);
		rpin(1'b0);
		chk("mat_out", 1, mo);
		wr(4'h0, 32'h10);
		set(6'h04, 6);
		chk("sw_out", 0, so);
		rpin(1'b1);
		chk("sw_out", 1, so);
		rpin(1'b0);
		wr(4'h8, 32'h5);
		wr(4'h0, 32'h900);
		set(6'h08, 10);
		chk("grip_err", 1, ge);
		chk("grip_out", 0, go);
		set(6'h20, 6);
		chk("grip_err", 0, ge);
		// A channel is pulsed once per six slots, so each window spans a full round
		wr(4'h0, 32'h888);
		short <= 6'h05;
		set(6'h07, 80);
		chk("mat_err", 1, me);
		chk("sw_err", 1, se);
		chk("mat_out", 0, mo);
		chk("sw_out", 0, so);
		rd(4'hc, 32'h298);
		@(posedge clk) short <= 6'h00;
		ms(80);
		chk("mat_err", 0, me);
		chk("sw_err", 0, se);
		chk("mat_out", 1, mo);
		chk("sw_out", 1, so);
		@(posedge clk) rstn <= 1'b0;
		repeat (20) @(posedge clk);
		rstn <= 1'b1;
		wr(4'h0, 32'h244);
		set(6'h1f, 6);
		chk("start_outs", 0, {mo, so, go});
		set(6'h00, 6);
		set(6'h1f, 6);
		chk("start_outs", 7, {mo, so, go});
		@(posedge clk) ce <= 1'b0;
		set(6'h00, 6);
		chk("frozen_outs", 7, {mo, so, go});
		@(posedge clk) ce <= 1'b1;
		ms(6);
		chk("thawed_outs", 0, {mo, so, go});
		summarize;
	end
endmodule // safety_input_evaluator_tb_top
